// ---- hdl/pfcv_pkg.sv ----
// constants, types and register map of the pfc valley and ovp logic
// Behaviour
// RQ1: sense above upper threshold sets demag latch
// RQ2: demag latch cleared at next pulse start
// RQ3: valley detect is latch AND inverted comparator
// RQ4: valley detect enables next turn-on
// RQ5: watchdog starts pulse when no valley found
// RQ6: floating sense pin holds switching off; in continuous mode the code keeps switching on its off-time timer
// RQ7: probe current; no pulse until pin high
// RQ8: ground sense pin 100 ns after turn-off
// RQ9: redundant overvoltage stops switching 800 us
// RQ10: redundant fault with low feedback latches off
// RQ11: feedback under 300 mV stops operation
// RQ12: sample feedback at 10 kHz, update control
// RQ13: command equals control, quarter in ccm high-line
// RQ14: no pulses while control at bottom
// RQ15: soft ovp above 105%, release below 103%
// RQ16: soft ovp scales command 75, 50, 25%
// RQ17: each step 400 us, then zero until clear
// RQ18: synchronise comparators, intervals from clock counters
package pfcv_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    localparam int T_BLANK_NS = 100;
    localparam int BLANK_CYC = (T_BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_STOP_US = 800;
    localparam int STOP_CYC = (T_STOP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int T_STEP_US = 400;
    localparam int STEP_CYC = (T_STEP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int F_SAMPLE_HZ = 10_000;
    localparam int SAMPLE_CYC = CLK_HZ / F_SAMPLE_HZ;
    localparam int T_WDOG_NS = 40_000;
    localparam int WDOG_CYC = T_WDOG_NS / CLK_NS;
    localparam int T_CCM_OFF_NS = 5_000;
    localparam int CCM_OFF_CYC = T_CCM_OFF_NS / CLK_NS;
    localparam int CW = 12;
    localparam int TW = 14;
    localparam int LOOP_SHIFT = 3;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_REF = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLAMP_BIT = 1;
    localparam int CTRL_CCM_BIT = 2;
    localparam int CTRL_HL_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h2;
    localparam logic [CW-1:0] REF_RST = 12'h800;
    localparam int STAT_STEP_LSB = 8;
    localparam int CMD_CTRL_LSB = 16;
    typedef struct packed {
        logic vs_high;
        logic redundant_overvoltage;
        logic fb_enh_low;
        logic fb_uv;
        logic fb_sovp_hi;
        logic fb_sovp_lo;
    } pfcv_cmp_t;
    typedef enum logic [2:0] {
        GS_IDLE = 3'b001,
        GS_PROBE = 3'b010,
        GS_ON = 3'b100
    } pfcv_gstate_t;
endpackage

// ---- hdl/pfcv_core.sv ----
// pfc valley detection, ovp supervision and gate-drive control
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/100ps
module pfcv_core import pfcv_pkg::*; #(
    parameter int STOP_CYCLES = STOP_CYC,
    parameter int STEP_CYCLES = STEP_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // analog front end
    input wire pfcv_cmp_t cmp_i,
    input wire logic [CW-1:0] fb_sample_i,
    // power stage
    output logic gate_drive_o,
    output logic vs_ground_o,
    output logic vs_probe_o,
    output logic [CW-1:0] ontime_command_o,
    output logic latched_off_o
);

////////////////////////////////////////////////////////////////////////
    pfcv_cmp_t cmp_m_r, cmp_s_r;
    pfcv_cmp_t cs;
    pfcv_gstate_t st_r, st_nxt;
    logic [3:0] ctrl_r;
    logic [CW-1:0] ref_r, ctrl_val_r, cmd_r, cmd_nxt, ctrl_nxt;
    logic [TW-1:0] off_cnt_r, on_cnt_r, stop_r, step_tmr_r, smp_cnt_r;
    logic [1:0] blank_r;
    logic [2:0] step_r;
    logic dmg_r, low_seen_r, float_r, latch_r, sovp_r;
    logic valley_detect, inhibit, wd_due, start, turn_off, trip, tick;
    logic en, clamp, continuous_mode, hline;
    logic signed [TW:0] err, acc;
    logic [31:0] rd_mux, status;
    logic acc_phase, hit;

    assign cs = cmp_s_r;
    assign en = ctrl_r[CTRL_EN_BIT];
    assign clamp = ctrl_r[CTRL_CLAMP_BIT];
    assign continuous_mode = ctrl_r[CTRL_CCM_BIT];
    assign hline = ctrl_r[CTRL_HL_BIT];

    // comparators are asynchronous to the core clock
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_m_r <= '0;
            cmp_s_r <= '0;
        end else begin
            cmp_m_r <= cmp_i; // see RQ18
            cmp_s_r <= cmp_m_r;
        end
    end

////////////////////////////////////////////////////////////////////////
    assign valley_detect = dmg_r & ~cs.vs_high; // see RQ3
    assign wd_due = off_cnt_r >= TW'(WDOG_CYC - 1);
    assign inhibit = ~en | latch_r | cs.fb_uv // see RQ11
        | (stop_r != '0) // see RQ9
        | (ctrl_val_r == '0) // see RQ14
        | (cmd_r == '0);
    assign start = (st_r != GS_ON) && (st_nxt == GS_ON);
    assign turn_off = (st_r == GS_ON) && (st_nxt != GS_ON);

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            GS_IDLE: begin
                if (!inhibit && blank_r == '0) begin
                    if (continuous_mode) begin
                        if (off_cnt_r >= TW'(CCM_OFF_CYC - 1)) begin
                            st_nxt = GS_ON;
                        end
                    end else if (valley_detect) begin
                        st_nxt = GS_ON; // see RQ4
                    end else if (clamp && wd_due && !float_r &&
                                 !(cs.vs_high && !low_seen_r)) begin
                        st_nxt = GS_PROBE; // see RQ5
                    end
                end
            end
            GS_PROBE: begin
                if (inhibit) begin
                    st_nxt = GS_IDLE;
                end else if (cs.vs_high) begin
                    st_nxt = GS_ON; // see RQ7
                end
            end
            GS_ON: begin
                if (inhibit || on_cnt_r >= TW'(cmd_r - 1'b1)) begin
                    st_nxt = GS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= GS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            off_cnt_r <= '0;
            on_cnt_r <= '0;
        end else begin
            on_cnt_r <= (st_r == GS_ON) ? on_cnt_r + 1'b1 : '0;
            if (st_r != GS_IDLE || start) begin
                off_cnt_r <= '0;
            end else if (!wd_due) begin
                off_cnt_r <= off_cnt_r + 1'b1;
            end
        end
    end

    // set only in the off-time so a probe-high cannot fake a valley
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dmg_r <= 1'b0;
        end else if (cs.vs_high && st_r == GS_IDLE && blank_r == '0) begin
            dmg_r <= 1'b1; // see RQ1
        end else if (start) begin
            dmg_r <= 1'b0; // see RQ2
        end
    end

    // a pin that never drops during a whole watchdog period is floating
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            low_seen_r <= 1'b0;
            float_r <= 1'b0;
        end else begin
            if (st_r == GS_IDLE && blank_r == '0 && !cs.vs_high) begin
                low_seen_r <= 1'b1;
                float_r <= 1'b0;
            end else if (start) begin
                low_seen_r <= 1'b0;
            end else if (st_r == GS_IDLE && wd_due && !low_seen_r &&
                         cs.vs_high) begin
                float_r <= 1'b1; // see RQ6
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            blank_r <= '0;
        end else if (turn_off) begin
            blank_r <= 2'(BLANK_CYC); // see RQ8
        end else if (blank_r != '0) begin
            blank_r <= blank_r - 1'b1;
        end
    end

    a_blank_len: assert property (@(posedge core_clk_i) // see RQ8
        disable iff (sys_rst_i) $fell(gate_drive_o) |-> vs_ground_o[*2])
        else $error("blanking not held two cycles after turn-off");
    a_probe_wait: assert property (@(posedge core_clk_i) // see RQ7
        disable iff (sys_rst_i)
        st_r == GS_PROBE && !cs.vs_high |=> !gate_drive_o)
        else $error("pulse issued before probe saw the pin high");
    a_bottom_idle: assert property (@(posedge core_clk_i) // see RQ14
        disable iff (sys_rst_i) ctrl_val_r == '0 |=> !$rose(gate_drive_o))
        else $error("pulse issued with control at bottom");
    a_uv_idle: assert property (@(posedge core_clk_i) // see RQ11
        disable iff (sys_rst_i) cs.fb_uv |=> !$rose(gate_drive_o))
        else $error("pulse issued during undervoltage");

////////////////////////////////////////////////////////////////////////
    // the synchroniser lag can leak turn-off noise just past blanking
    assign trip = cs.redundant_overvoltage && blank_r == '0;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stop_r <= '0;
            latch_r <= 1'b0;
        end else begin
            if (trip) begin
                stop_r <= TW'(STOP_CYCLES); // see RQ9
            end else if (stop_r != '0) begin
                stop_r <= stop_r - 1'b1;
            end
            if (trip && cs.fb_enh_low) begin
                latch_r <= 1'b1; // see RQ10
            end
        end
    end

    a_redundant_overvoltage_stop: assert property (@(posedge core_clk_i) // see RQ9
        disable iff (sys_rst_i) stop_r != '0 |=> !$rose(gate_drive_o))
        else $error("pulse issued during redundant overvoltage stop");
    a_latch_off: assert property (@(posedge core_clk_i) // see RQ10
        disable iff (sys_rst_i) latch_r |=> ##1 latch_r && !gate_drive_o)
        else $error("latched-off state released or switching");

////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sovp_r <= 1'b0;
        end else if (cs.fb_sovp_hi) begin
            sovp_r <= 1'b1; // see RQ15
        end else if (cs.fb_sovp_lo) begin
            sovp_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            step_r <= '0;
            step_tmr_r <= '0;
        end else if (!sovp_r) begin
            step_r <= '0;
        end else if (step_r == '0 || (step_r < 3'd4 && step_tmr_r == '0)) begin
            step_r <= step_r + 1'b1; // see RQ17
            step_tmr_r <= TW'(STEP_CYCLES - 1);
        end else if (step_tmr_r != '0) begin
            step_tmr_r <= step_tmr_r - 1'b1;
        end
    end

    always_comb begin
        cmd_nxt = ctrl_val_r;
        if (sovp_r) begin
            unique case (step_r)
                3'd1: cmd_nxt = ctrl_val_r - (ctrl_val_r >> 2); // see RQ16
                3'd2: cmd_nxt = ctrl_val_r >> 1;
                3'd3: cmd_nxt = ctrl_val_r >> 2;
                3'd4: cmd_nxt = '0; // see RQ17
                default: cmd_nxt = ctrl_val_r;
            endcase
        end else if (continuous_mode && hline) begin
            cmd_nxt = ctrl_val_r >> 2; // see RQ13
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_r <= '0;
        end else begin
            cmd_r <= cmd_nxt; // see RQ13
        end
    end

    a_sovp_hold: assert property (@(posedge core_clk_i) // see RQ15
        disable iff (sys_rst_i) sovp_r && !cs.fb_sovp_lo |=> sovp_r)
        else $error("soft overvoltage released above release level");
    a_sovp_zero: assert property (@(posedge core_clk_i) // see RQ17
        disable iff (sys_rst_i) sovp_r && step_r == 3'd4 |=> cmd_r == '0)
        else $error("command not zero in last soft overvoltage step");

////////////////////////////////////////////////////////////////////////
    assign tick = smp_cnt_r == TW'(SAMPLE_CYC - 1);
    assign err = $signed({3'b000, ref_r}) - $signed({3'b000, fb_sample_i});
    assign acc = $signed({3'b000, ctrl_val_r}) + (err >>> LOOP_SHIFT);

    always_comb begin
        if (acc < 0) begin
            ctrl_nxt = '0;
        end else if (acc > $signed({3'b000, {CW{1'b1}}})) begin
            ctrl_nxt = {CW{1'b1}};
        end else begin
            ctrl_nxt = acc[CW-1:0];
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            smp_cnt_r <= '0;
            ctrl_val_r <= '0;
        end else begin
            smp_cnt_r <= tick ? '0 : smp_cnt_r + 1'b1;
            if (tick) begin
                ctrl_val_r <= ctrl_nxt; // see RQ12
            end
        end
    end

////////////////////////////////////////////////////////////////////////
    assign acc_phase = psel_i & penable_i;
    assign hit = paddr_i == REG_CTRL || paddr_i == REG_STATUS ||
                 paddr_i == REG_REF || paddr_i == REG_CMD;
    assign pready_o = 1'b1;
    assign pslverr_o = acc_phase & ~hit;
    assign status = {21'h0, step_r, 1'b0, float_r, sovp_r, latch_r,
                     stop_r != '0, cs.fb_uv, valley_detect, dmg_r};

    always_comb begin
        rd_mux = '0;
        unique case (paddr_i)
            REG_CTRL: rd_mux = {28'h000_0000, ctrl_r};
            REG_STATUS: rd_mux = status;
            REG_REF: rd_mux = {20'h0_0000, ref_r};
            REG_CMD: rd_mux = {4'h0, ctrl_val_r, 4'h0, cmd_r};
            default: rd_mux = '0;
        endcase
    end

    // read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_o <= '0;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_mux;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_r <= CTRL_RST;
            ref_r <= REF_RST;
        end else if (acc_phase && pwrite_i) begin
            if (paddr_i == REG_CTRL) begin
                ctrl_r <= pwdata_i[3:0];
            end
            if (paddr_i == REG_REF) begin
                ref_r <= pwdata_i[CW-1:0];
            end
        end
    end

    assign gate_drive_o = st_r == GS_ON;
    assign vs_ground_o = blank_r != '0;
    assign vs_probe_o = st_r == GS_PROBE;
    assign ontime_command_o = cmd_r;
    assign latched_off_o = latch_r;

endmodule // pfcv_core

// ---- tb/pfcv_stage_model.sv ----
// boost stage and valley-sense pin model seen by the pfc valley logic
`timescale 1ns/100ps
module pfcv_stage_model #(
    parameter int DEMAG_CYC = 30
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // device pins
    input wire logic gate_drive_i,
    input wire logic vs_ground_i,
    input wire logic vs_probe_i,
    // 0 normal, 1 no ringing, 2 pin grounded, 3 pin floating
    input wire logic [1:0] mode_i,
    output logic vs_high_o
);
    logic [7:0] demag_r;
    // core resets for a fixed time after each turn-off
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            demag_r <= 8'h00;
        end else if (gate_drive_i) begin
            demag_r <= 8'(DEMAG_CYC);
        end else if (demag_r != 8'h00) begin
            demag_r <= demag_r - 8'h01;
        end
    end
    always_comb begin
        case (mode_i)
            2'h3: vs_high_o = 1'b1;
            2'h2: vs_high_o = 1'b0;
            // the winding swings negative while the switch conducts
            default: vs_high_o = !vs_ground_i && (vs_probe_i ||
                (mode_i == 2'h0 && !gate_drive_i &&
                 demag_r != 8'h00));
        endcase
    end
endmodule // pfcv_stage_model

// ---- tb/pfc_valley_and_ovp_logic_tb.sv ----
// self-checking bench for the pfc valley and ovp logic
`timescale 1ns/100ps
module pfc_valley_and_ovp_logic_tb import pfcv_pkg::*;;
    localparam int STOP_T = 40;
    typedef struct packed {
        logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;
    } pfcv_row_t;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata_o, rd;
    logic pready_o, pslverr_o, gate_drive_o, vs_ground_o, vs_probe_o, er;
    logic latched_off_o, vs_high, g_q = 1'b0;
    logic [CW-1:0] ontime_command_o, ctrl;
    logic [CW-1:0] fb_sample = 12'h800;
    logic [1:0] mode = 2'h0;
    logic redundant_overvoltage = 1'b0, enh_low = 1'b0, uv = 1'b0, s_hi = 1'b0, s_lo = 1'b0;
    pfcv_cmp_t cmp;
    int err_total = 0, comparisons = 0, rises = 0, gap_n;
    pfcv_row_t rows [10] = '{
        '{1'b0, REG_CTRL, 32'h0000_0000, 32'h0000_0002, 1'b0},
        '{1'b0, REG_REF, 32'h0000_0000, 32'h0000_0800, 1'b0},
        '{1'b0, REG_CMD, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, 8'h40, 32'h0000_0005, 32'h0000_0000, 1'b1},
        '{1'b0, 8'h40, 32'h0000_0000, 32'h0000_0000, 1'b1},
        '{1'b1, REG_REF, 32'h0000_0123, 32'h0000_0000, 1'b0},
        '{1'b0, REG_REF, 32'h0000_0000, 32'h0000_0123, 1'b0},
        '{1'b1, REG_CMD, 32'h0000_0fff, 32'h0000_0000, 1'b0},
        '{1'b0, REG_CMD, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, REG_REF, 32'h0000_0800, 32'h0000_0000, 1'b0}};
    assign cmp = {vs_high, redundant_overvoltage, enh_low, uv, s_hi, s_lo};
    initial forever #25 core_clk_i = ~core_clk_i;
    pfcv_core #(.STOP_CYCLES(STOP_T), .STEP_CYCLES(20)) pfcv_core_inst (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .cmp_i(cmp), .fb_sample_i(fb_sample),
        .gate_drive_o(gate_drive_o), .vs_ground_o(vs_ground_o),
        .vs_probe_o(vs_probe_o), .ontime_command_o(ontime_command_o),
        .latched_off_o(latched_off_o));
    pfcv_stage_model pfcv_stage_model_inst (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .gate_drive_i(gate_drive_o), .vs_ground_i(vs_ground_o),
        .vs_probe_i(vs_probe_o), .mode_i(mode), .vs_high_o(vs_high));
    always @(posedge core_clk_i) begin
        g_q <= gate_drive_o;
        if (gate_drive_o === 1'b1 && g_q !== 1'b1) rises <= rises + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        cyc(1);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        cyc(1);
        penable <= 1'b1;
        cyc(1);
        // only the watchdog ends a wait for the answer
        while (pready_o !== 1'b1) begin
            cyc(1);
        end
        rd = prdata_o;
        er = pslverr_o;
        chk("apb answer", pready_o, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // counts gate rises over a span; only presence or absence is judged
    task automatic span(input int n, input logic some, input string what);
        int r0;
        r0 = rises;
        cyc(n);
        chk(what, 32'(rises != r0), 32'(some));
    endtask
    // one whole pulse, its blanking, then the off-time to the next rise
    task automatic gap(output int off);
        int w;
        w = 0;
        off = 0;
        // a pulse already under way is skipped so only whole ones are timed
        while (gate_drive_o === 1'b1 && off < 3000) begin
            cyc(1);
            off++;
        end
        while (gate_drive_o !== 1'b1 && off < 3000) begin
            cyc(1);
            off++;
        end
        while (gate_drive_o === 1'b1 && w < 5000) begin
            cyc(1);
            w++;
        end
        chk("pulse width", w, ontime_command_o);
        chk("pulse seen", off < 3000, 32'h1);
        off = 0;
        w = 0;
        while (gate_drive_o !== 1'b1 && off < 3000) begin
            if (off < 8 && vs_ground_o === 1'b1) w++;
            cyc(1);
            off++;
        end
        chk("blanking", w, 32'h2);
        chk("next pulse", off < 3000, 32'h1);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(60000);
        err_total++;
        conclude;
    end
    initial begin
        cyc(3);
        sys_rst_i <= 1'b0;
        chk("reset outs", {gate_drive_o, vs_probe_o, latched_off_o,
            pready_o}, 32'h1);
        chk("reset rdata", prdata_o, 32'h0);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("read data", rd, rows[i].x);
            chk("slave error", er, 32'(rows[i].e));
        end
        $display("register rows done");
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        fb_sample <= 12'h700;
        cyc(4500);
        fb_sample <= 12'h800;
        cyc(10);
        apb(1'b0, REG_CMD, 32'h0000_0000);
        ctrl = rd[27:16];
        chk("loop step", {ctrl[4:0], ctrl != 12'h000}, 32'h1);
        chk("command", rd[11:0], ctrl);
        gap(gap_n);
        chk("valley wait", gap_n > 20 && gap_n < 200, 32'h1);
        $display("valley test done");
        uv <= 1'b1;
        cyc(10);
        span(300, 1'b0, "uv stop");
        uv <= 1'b0;
        span(1200, 1'b1, "uv resume");
        // held past a blanking interval so the trip cannot be masked
        redundant_overvoltage <= 1'b1;
        cyc(4);
        redundant_overvoltage <= 1'b0;
        cyc(4);
        span(STOP_T - 10, 1'b0, "redundant_overvoltage stop");
        chk("no latch", latched_off_o, 32'h0);
        span(1200, 1'b1, "redundant_overvoltage resume");
        $display("fault stop tests done");
        s_hi <= 1'b1;
        cyc(10);
        chk("step 75", ontime_command_o, ctrl * 3 / 4);
        s_hi <= 1'b0;
        cyc(20);
        chk("step 50", ontime_command_o, ctrl / 2);
        cyc(20);
        chk("step 25", ontime_command_o, ctrl / 4);
        cyc(20);
        chk("step 0", ontime_command_o, 32'h0);
        span(40, 1'b0, "soft hold");
        s_lo <= 1'b1;
        cyc(10);
        chk("soft clear", ontime_command_o, ctrl);
        s_lo <= 1'b0;
        $display("soft ovp test done");
        apb(1'b1, REG_CTRL, 32'h0000_000d);
        cyc(10);
        chk("quarter", ontime_command_o, ctrl / 4);
        gap(gap_n);
        apb(1'b1, REG_CTRL, 32'h0000_0005);
        cyc(10);
        chk("ccm low line", ontime_command_o, ctrl);
        gap(gap_n);
        $display("continuous mode test done");
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        mode <= 2'h1;
        gap(gap_n);
        gap(gap_n);
        chk("watchdog", gap_n >= 790 && gap_n < 840, 32'h1);
        mode <= 2'h2;
        cyc(100);
        span(2500, 1'b0, "grounded");
        chk("probe", vs_probe_o, 32'h1);
        mode <= 2'h0;
        span(100, 1'b1, "probe answered");
        mode <= 2'h3;
        cyc(2000);
        span(2000, 1'b0, "floating");
        mode <= 2'h0;
        $display("pin fault tests done");
        fb_sample <= 12'hfff;
        cyc(2100);
        apb(1'b0, REG_CMD, 32'h0000_0000);
        chk("control floor", rd[27:16], 32'h0);
        span(1000, 1'b0, "static ovp");
        enh_low <= 1'b1;
        redundant_overvoltage <= 1'b1;
        cyc(5);
        chk("latch off", latched_off_o, 32'h1);
        redundant_overvoltage <= 1'b0;
        enh_low <= 1'b0;
        fb_sample <= 12'h700;
        span(STOP_T * 5, 1'b0, "latched");
        chk("latch held", latched_off_o, 32'h1);
        sys_rst_i <= 1'b1;
        cyc(2);
        sys_rst_i <= 1'b0;
        cyc(1);
        chk("latch reset", latched_off_o, 32'h0);
        $display("latch test done");
        conclude;
    end
endmodule // pfc_valley_and_ovp_logic_tb
